//--- include/arc_pkg.sv
// Constants, types and helpers for one ARINC 429 receive channel.
// Assumes a 20 MHz mclk and an external 1 MHz sampling reference.
package arc_pkg;

  localparam int ARC_MCLK_PERIOD_NS = 50;
  localparam int ARC_REF_PERIOD_NS = 1000;
  // Reference period in mclk cycles at the nominal 1 MHz reference
  localparam int ARC_REF_CYCLES = ARC_REF_PERIOD_NS / ARC_MCLK_PERIOD_NS;

  localparam int ARC_WORD_W = 32;
  localparam int ARC_LBL_W = 8;
  localparam int ARC_LBL_N = 16;
  localparam int ARC_SR_W = 10;

  // Bit positions inside a stored word (index 0 is ARINC bit 1)
  localparam int ARC_POS_PAR = 31;
  localparam int ARC_POS_B10 = 9;
  localparam int ARC_POS_B9 = 8;

  localparam logic [5:0] ARC_LAST_BIT = 6'h1f;
  localparam logic [3:0] ARC_SPACE_MIN = 4'h8;
  localparam logic [3:0] ARC_SPACE_MAX = 4'hc;
  localparam logic [3:0] ARC_SPACE_SAT = 4'hd;
  localparam logic [3:0] ARC_GAP_LAST = 4'h9;
  localparam logic [1:0] ARC_GAP_NEED = 2'h3;
  localparam logic [2:0] ARC_SLOW_LAST = 3'h7;
  localparam logic [5:0] ARC_TX_HALF_FAST = 6'h05;
  localparam logic [5:0] ARC_TX_HALF_SLOW = 6'h28;
  localparam logic [2:0] ARC_FIFO_N = 3'h4;
  localparam logic [1:0] ARC_PTR_ONE = 2'h1;
  localparam logic [2:0] ARC_CNT_ONE = 3'h1;

  typedef enum logic [1:0] {
    ARC_RX_GAP = 2'b00,
    ARC_RX_WORD = 2'b01
  } arc_rx_state_e;

  // Three consecutive ones anywhere in a five-sample half
  function automatic logic arc_run3(input logic [4:0] v);
    arc_run3 = (v[0] & v[1] & v[2]) | (v[1] & v[2] & v[3]) | (v[2] & v[3] & v[4]);
  endfunction

  function automatic logic [7:0] arc_rev8(input logic [7:0] v);
    arc_rev8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction

endpackage

//--- rtl/arc_word_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; clr drops both entries at once.
module arc_word_buf #(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  typedef struct packed {
    logic out_v;
    logic [W-1:0] out_d;
    logic skid_v;
    logic [W-1:0] skid_d;
  } arc_buf_s;

  arc_buf_s s_q;
  arc_buf_s s_d;
  logic take;

  // Ready comes from a flop, so the source never sees a combinational loop
  assign in_ready = ~s_q.skid_v;
  assign out_valid = s_q.out_v;
  assign out_data = s_q.out_d;

  always_comb begin
    s_d = s_q;
    take = in_valid & ~s_q.skid_v;
    if (!s_q.out_v || out_ready) begin
      if (s_q.skid_v) begin
        s_d.out_d = s_q.skid_d;
        s_d.skid_v = 1'b0;
      end else begin
        s_d.out_v = take;
        s_d.out_d = in_data;
      end
    end else if (take) begin
      s_d.skid_v = 1'b1;
      s_d.skid_d = in_data;
    end
    if (clr) begin
      s_d.out_v = 1'b0;
      s_d.skid_v = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // arc_word_buf

//--- rtl/arc_rx_channel.sv
// One ARINC 429 receive channel with label filter, word queue and test transmitter.
// Assumes line receiver band pins and a 1 MHz reference, both asynchronous to mclk.
module arc_rx_channel
  import arc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sample_ref_in,
  input wire logic line_one_band,
  input wire logic line_zero_band,
  input wire logic line_null_band,
  input wire logic rate_high_speed,
  input wire logic label_filter_enable,
  input wire logic sdi_decoder_enable,
  input wire logic bit10_match_value,
  input wire logic bit9_match_value,
  input wire logic loopback_select_n,
  input wire logic parity_check_enable,
  input wire logic channel_reset_bit,
  input wire logic label_order_select,
  input wire logic ctrl_wr,
  input wire logic lbl_wr_en,
  input wire logic [3:0] lbl_wr_idx,
  input wire logic [7:0] lbl_wr_data,
  input wire logic [3:0] lbl_rd_idx,
  output logic [7:0] lbl_rd_data,
  input wire logic word_rd_ready,
  output logic word_rd_valid,
  output logic [31:0] word_rd_data,
  input wire logic tx_load,
  input wire logic tx_high_speed,
  input wire logic [31:0] tx_word,
  output logic tx_high_level_out,
  output logic tx_low_level_out,
  output logic end_of_word_strobe,
  output logic fifo_empty_flags,
  output logic fifo_full_flags
);

  typedef struct packed {
    logic [2:0] ref_sy;
    logic ref_f;
    logic [2:0] band_s1, band_s2, band_s3, band_f, pre;
    logic [ARC_SR_W-1:0] one_sr, zero_sr, null_sr;
    logic det;
    arc_rx_state_e st;
    logic [3:0] gap_tmr;
    logic [1:0] gap_cnt;
    logic [3:0] space;
    logic [5:0] bits;
    logic [ARC_WORD_W-1:0] word;
    logic eow;
    logic [ARC_LBL_N-1:0][ARC_LBL_W-1:0] lbl;
    logic [ARC_LBL_W-1:0] lbl_rd;
    logic [3:0][ARC_WORD_W-1:0] fifo;
    logic [1:0] wr, rd;
    logic [2:0] cnt;
    logic empty, full;
    logic [ARC_WORD_W-1:0] tx_sh;
    logic [5:0] tx_bits, tx_tmr;
    logic tx_null, tx_act, tx_fast, tx_hi, tx_lo;
  } arc_chan_s;

  arc_chan_s s_q;
  arc_chan_s s_d;

  logic tick, samp, det_now, bit_now, rise, done, keep, push, pop, chan_rst;
  logic buf_ready, buf_valid;
  logic [2:0] src, cnt_n;
  logic [3:0] space_n;
  logic [5:0] tx_half;
  logic [ARC_WORD_W-1:0] done_word, fin_word, head_fmt;
  logic [ARC_LBL_W-1:0] cand_lbl;
  logic [ARC_LBL_N-1:0] lbl_hit;

  // Word as it stands with the current bit shifted in; index 0 is ARINC bit 1
  assign bit_now = arc_run3(s_q.one_sr[9:5]);
  assign done_word = {bit_now, s_q.word[ARC_WORD_W-1:1]};
  assign cand_lbl = arc_rev8(done_word[7:0]);

  genvar gi;
  generate
    for (gi = 0; gi < ARC_LBL_N; gi++) begin : g_lbl
      assign lbl_hit[gi] = (s_q.lbl[gi] == cand_lbl);
    end
  endgenerate

  // Oldest word, packed in host read order
  assign head_fmt = {s_q.fifo[s_q.rd][ARC_WORD_W-1:8],
    label_order_select ? s_q.fifo[s_q.rd][7:0] : arc_rev8(s_q.fifo[s_q.rd][7:0])};

  always_comb begin
    s_d = s_q;
    chan_rst = channel_reset_bit | ctrl_wr;

    // Pin inputs: three flops, a change counts once stages two and three agree
    s_d.ref_sy = {s_q.ref_sy[1:0], sample_ref_in};
    tick = 1'b0;
    if (s_q.ref_sy[1] == s_q.ref_sy[2]) begin
      s_d.ref_f = s_q.ref_sy[2];
      tick = s_q.ref_sy[2] & ~s_q.ref_f;
    end
    s_d.band_s1 = {line_one_band, line_zero_band, line_null_band};
    s_d.band_s2 = s_q.band_s1;
    s_d.band_s3 = s_q.band_s2;
    s_d.band_f = (~(s_q.band_s2 ^ s_q.band_s3) & s_q.band_s3) |
      ((s_q.band_s2 ^ s_q.band_s3) & s_q.band_f);

    // Low speed samples every eighth reference tick
    if (tick) begin
      s_d.pre = s_q.pre + 3'h1;
    end
    samp = tick & (rate_high_speed | (s_q.pre == ARC_SLOW_LAST));

    // Test transmitter, first loaded bit goes out first
    tx_half = s_q.tx_fast ? ARC_TX_HALF_FAST : ARC_TX_HALF_SLOW;
    if (tx_load) begin
      s_d.tx_sh = tx_word;
      s_d.tx_bits = '0;
      s_d.tx_tmr = '0;
      s_d.tx_null = 1'b0;
      s_d.tx_act = 1'b1;
      s_d.tx_fast = tx_high_speed;
    end else if (s_q.tx_act && tick) begin
      if (s_q.tx_tmr == tx_half - 6'h01) begin
        s_d.tx_tmr = '0;
        if (!s_q.tx_null) begin
          s_d.tx_null = 1'b1;
        end else begin
          s_d.tx_null = 1'b0;
          s_d.tx_sh = {1'b0, s_q.tx_sh[ARC_WORD_W-1:1]};
          s_d.tx_bits = s_q.tx_bits + 6'h01;
          s_d.tx_act = (s_q.tx_bits != ARC_LAST_BIT);
        end
      end else begin
        s_d.tx_tmr = s_q.tx_tmr + 6'h01;
      end
    end
    s_d.tx_hi = s_d.tx_act & ~s_d.tx_null & s_d.tx_sh[0];
    s_d.tx_lo = s_d.tx_act & ~s_d.tx_null & ~s_d.tx_sh[0];

    // Loopback takes the transmitter only when its rate matches ours
    if (!loopback_select_n) begin
      src = (s_q.tx_fast == rate_high_speed) ?
        {s_q.tx_hi, s_q.tx_lo, ~s_q.tx_hi & ~s_q.tx_lo} : 3'h0;
    end else begin
      src = s_q.band_f;
    end

    // Sample registers, newest sample at bit 0
    det_now = (arc_run3(s_q.one_sr[9:5]) | arc_run3(s_q.zero_sr[9:5])) &
      arc_run3(s_q.null_sr[4:0]);
    rise = 1'b0;
    done = 1'b0;
    space_n = (s_q.space == ARC_SPACE_SAT) ? s_q.space : s_q.space + 4'h1;
    if (samp) begin
      s_d.one_sr = {s_q.one_sr[ARC_SR_W-2:0], src[2]};
      s_d.zero_sr = {s_q.zero_sr[ARC_SR_W-2:0], src[1]};
      s_d.null_sr = {s_q.null_sr[ARC_SR_W-2:0], src[0]};
      s_d.det = det_now;
      rise = det_now & ~s_q.det;
      case (s_q.st)
        ARC_RX_GAP: begin
          s_d.gap_tmr = s_q.gap_tmr + 4'h1;
          if (s_q.gap_tmr == ARC_GAP_LAST) begin
            s_d.gap_tmr = '0;
            if (arc_run3(s_q.null_sr[9:5]) && arc_run3(s_q.null_sr[4:0])) begin
              s_d.gap_cnt = s_q.gap_cnt + 2'h1;
              if (s_q.gap_cnt + 2'h1 == ARC_GAP_NEED) begin
                s_d.st = ARC_RX_WORD;
                s_d.bits = '0;
                s_d.space = '0;
              end
            end else begin
              s_d.gap_cnt = '0;
            end
          end
        end
        ARC_RX_WORD: begin
          if (s_q.bits != 6'h00) begin
            s_d.space = space_n;
          end
          if (rise) begin
            if (s_q.bits != 6'h00 && (space_n < ARC_SPACE_MIN || space_n > ARC_SPACE_MAX)) begin
              s_d.st = ARC_RX_GAP;
              s_d.gap_cnt = '0;
              s_d.gap_tmr = '0;
            end else begin
              s_d.word = done_word;
              s_d.space = '0;
              s_d.bits = s_q.bits + 6'h01;
              if (s_q.bits == ARC_LAST_BIT) begin
                done = 1'b1;
                s_d.st = ARC_RX_GAP;
                s_d.gap_cnt = '0;
                s_d.gap_tmr = '0;
                s_d.bits = '0;
              end
            end
          end else if (s_q.bits != 6'h00 && space_n > ARC_SPACE_MAX) begin
            s_d.st = ARC_RX_GAP;
            s_d.gap_cnt = '0;
            s_d.gap_tmr = '0;
          end
        end
        default: begin
          s_d.st = ARC_RX_GAP;
        end
      endcase
    end

    // Parity flag and load filter
    fin_word = done_word;
    if (parity_check_enable) begin
      fin_word[ARC_POS_PAR] = ~(^done_word);
    end
    keep = (!label_filter_enable || (|lbl_hit)) &&
      (!sdi_decoder_enable || (fin_word[ARC_POS_B10] == bit10_match_value &&
      fin_word[ARC_POS_B9] == bit9_match_value));
    s_d.eow = done;
    push = done & keep;

    // Queue; the buffer pulls the oldest word whenever it has room
    pop = (s_q.cnt != 3'h0) & buf_ready;
    cnt_n = s_q.cnt;
    if (pop) begin
      s_d.rd = s_q.rd + ARC_PTR_ONE;
      cnt_n = cnt_n - ARC_CNT_ONE;
    end
    if (push) begin
      if (cnt_n == ARC_FIFO_N) begin
        s_d.fifo[s_q.wr - ARC_PTR_ONE] = fin_word;
      end else begin
        s_d.fifo[s_q.wr] = fin_word;
        s_d.wr = s_q.wr + ARC_PTR_ONE;
        cnt_n = cnt_n + ARC_CNT_ONE;
      end
    end
    s_d.cnt = cnt_n;
    // Empty lags the host's last take by one cycle, never leads a load
    s_d.empty = (cnt_n == 3'h0) & ~pop & ~buf_valid;
    s_d.full = (cnt_n == ARC_FIFO_N);

    // Label table access
    if (lbl_wr_en) begin
      s_d.lbl[lbl_wr_idx] = lbl_wr_data;
    end
    s_d.lbl_rd = s_q.lbl[lbl_rd_idx];

    if (ctrl_wr) begin
      s_d.lbl = '0;
    end
    if (chan_rst) begin
      s_d.st = ARC_RX_GAP;
      s_d.gap_cnt = '0;
      s_d.gap_tmr = '0;
      s_d.bits = '0;
      s_d.space = '0;
      s_d.det = 1'b0;
      s_d.one_sr = '0;
      s_d.zero_sr = '0;
      s_d.null_sr = '0;
      s_d.eow = 1'b0;
      s_d.cnt = '0;
      s_d.wr = '0;
      s_d.rd = '0;
      s_d.empty = 1'b1;
      s_d.full = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  arc_word_buf #(
    .W(ARC_WORD_W)
  ) u_buf (
    .mclk(mclk),
    .resetn(resetn),
    .clr(chan_rst),
    .in_valid(s_q.cnt != 3'h0),
    .in_ready(buf_ready),
    .in_data(head_fmt),
    .out_valid(buf_valid),
    .out_ready(word_rd_ready),
    .out_data(word_rd_data)
  );

  assign word_rd_valid = buf_valid;
  assign lbl_rd_data = s_q.lbl_rd;
  assign tx_high_level_out = s_q.tx_hi;
  assign tx_low_level_out = s_q.tx_lo;
  assign end_of_word_strobe = s_q.eow;
  assign fifo_empty_flags = s_q.empty;
  assign fifo_full_flags = s_q.full;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  eow_to_gap_a: assert property (s_q.eow |-> s_q.st == ARC_RX_GAP && s_q.gap_cnt == 2'h0)
    else $error("end of word without return to gap wait");
  full_flag_a: assert property (s_q.cnt == ARC_FIFO_N && !pop && !chan_rst
    |=> fifo_full_flags)
    else $error("full flag missing at four words");
  overwrite_hold_a: assert property (push && s_q.cnt == ARC_FIFO_N && !pop && !chan_rst
    |=> s_q.cnt == ARC_FIFO_N && s_q.wr == $past(s_q.wr))
    else $error("overflow word changed queue depth");
  load_clears_empty_a: assert property (push && !chan_rst |=> !fifo_empty_flags)
    else $error("empty flag still set after load");
  drop_silent_a: assert property (done && !keep && !pop && !chan_rst |=> $stable(s_q.cnt))
    else $error("filtered word changed queue");
  bit_spacing_a: assert property (rise && s_q.st == ARC_RX_WORD && s_q.bits != 6'h00 &&
    s_d.bits != 6'h00 && s_d.st == ARC_RX_WORD |-> space_n >= ARC_SPACE_MIN &&
    space_n <= ARC_SPACE_MAX)
    else $error("bit accepted outside spacing window");
  gap_enable_a: assert property (s_q.st == ARC_RX_GAP ##1 s_q.st == ARC_RX_WORD
    |-> $past(s_q.gap_cnt) == 2'h2)
    else $error("reception enabled before three gap nulls");
  tx_code_a: assert property (!(tx_high_level_out && tx_low_level_out))
    else $error("both transmit pins high");
  parity_store_a: assert property (push && parity_check_enable && s_q.cnt < ARC_FIFO_N &&
    !pop && !chan_rst |=> s_q.fifo[$past(s_q.wr)][ARC_POS_PAR] == !(^$past(done_word)))
    else $error("stored parity flag wrong");
  chan_reset_a: assert property (channel_reset_bit |=> fifo_empty_flags && !fifo_full_flags &&
    s_q.st == ARC_RX_GAP)
    else $error("channel reset did not clear queue");
  ref_spacing_a: assert property (tick |=> !tick [*2])
    else $error("reference ticks too close");

endmodule // arc_rx_channel

//--- test/arc_tx_model.sv
// ARINC 429 transmitter model driving the three line-receiver band pins.
// Assumes the bench makes the sampling reference; bands move on its fall.
module arc_tx_model (
  input wire logic sample_ref_in,
  output logic line_one_band,
  output logic line_zero_band,
  output logic line_null_band
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus sits at Null, so gap counting can start at once
  initial begin
    {line_one_band, line_zero_band, line_null_band} = 3'b001;
  end

  task automatic hold(input logic [2:0] lvl, input int n);
    {line_one_band, line_zero_band, line_null_band} = lvl;
    repeat (n) @(negedge sample_ref_in);
  endtask

  // Late bit index stretches one Null so the next bit comes 15 samples on
  task automatic send(input logic [31:0] w, input int late_bit);
    @(negedge sample_ref_in);
    for (int i = 0; i < 32; i++) begin
      hold(w[i] ? 3'b100 : 3'b010, 5);
      hold(3'b001, (i == late_bit) ? 10 : 5);
    end
    hold(3'b001, 40);
  endtask
endmodule // arc_tx_model

//--- test/tb_arc_rx_channel.sv
// Self-checking bench for one receive channel, label table first, then rows, then edge cases.
// Assumes the transmitter model and a fast sampling reference of 8 mclk.
module tb_arc_rx_channel
  import arc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [31:0] w;
    logic [5:0] cfg;
    logic load;
  } arc_row_s;

  logic mclk, resetn, sample_ref_in, one_b, zero_b, null_b;
  logic label_filter_enable, sdi_decoder_enable, bit10_match_value, bit9_match_value;
  logic loopback_select_n, parity_check_enable, channel_reset_bit, label_order_select;
  logic ctrl_wr, lbl_wr_en, word_rd_ready, word_rd_valid, tx_load;
  logic tx_high_level_out, tx_low_level_out, end_of_word_strobe;
  logic fifo_empty_flags, fifo_full_flags;
  logic [3:0] lbl_wr_idx, lbl_rd_idx;
  logic [7:0] lbl_wr_data, lbl_rd_data;
  logic [31:0] word_rd_data, tx_word;
  int errors = 0;
  int num_checks = 0;
  // Config bits: filter, decoder, bit10, bit9, parity, label order
  arc_row_s rows[10] = '{
    '{32'h8123_451b, 6'b000000, 1'b1}, '{32'h8123_451b, 6'b000001, 1'b1},
    '{32'h0000_0001, 6'b000010, 1'b1}, '{32'h0000_0003, 6'b000010, 1'b1},
    '{32'h4567_891b, 6'b100001, 1'b1}, '{32'h4567_8922, 6'b100000, 1'b0},
    '{32'h4567_8a00, 6'b100000, 1'b1}, '{32'h0000_0200, 6'b011000, 1'b1},
    '{32'h0000_0100, 6'b011000, 1'b0}, '{32'h1234_561b, 6'b110100, 1'b0}};

  arc_tx_model bus (.sample_ref_in(sample_ref_in), .line_one_band(one_b),
    .line_zero_band(zero_b), .line_null_band(null_b));

  arc_rx_channel dut (.mclk(mclk), .resetn(resetn), .sample_ref_in(sample_ref_in),
    .line_one_band(one_b), .line_zero_band(zero_b), .line_null_band(null_b),
    .rate_high_speed(1'b1), .label_filter_enable(label_filter_enable),
    .sdi_decoder_enable(sdi_decoder_enable), .bit10_match_value(bit10_match_value),
    .bit9_match_value(bit9_match_value), .loopback_select_n(loopback_select_n),
    .parity_check_enable(parity_check_enable), .channel_reset_bit(channel_reset_bit),
    .label_order_select(label_order_select), .ctrl_wr(ctrl_wr), .lbl_wr_en(lbl_wr_en),
    .lbl_wr_idx(lbl_wr_idx), .lbl_wr_data(lbl_wr_data), .lbl_rd_idx(lbl_rd_idx),
    .lbl_rd_data(lbl_rd_data), .word_rd_ready(word_rd_ready),
    .word_rd_valid(word_rd_valid), .word_rd_data(word_rd_data), .tx_load(tx_load),
    .tx_high_speed(1'b1), .tx_word(tx_word), .tx_high_level_out(tx_high_level_out),
    .tx_low_level_out(tx_low_level_out), .end_of_word_strobe(end_of_word_strobe),
    .fifo_empty_flags(fifo_empty_flags), .fifo_full_flags(fifo_full_flags));

  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end

  // Faster than 1 MHz to keep the run short; phase unrelated to mclk
  initial begin
    sample_ref_in = 0;
    #7;
    forever #200 sample_ref_in = ~sample_ref_in;
  end

  function automatic logic [7:0] rv(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rv[i] = v[7 - i];
  endfunction

  function automatic logic [31:0] exp_word(input logic [31:0] w, input logic par,
                                           input logic ord);
    exp_word = {par ? ~^w : w[31], w[30:8], ord ? w[7:0] : rv(w[7:0])};
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // A negative late index only watches, for test words from the transmitter
  task automatic rx_word(input logic [31:0] w, input int late, input logic eow);
    logic seen;
    seen = 0;
    fork
      if (late >= 0) bus.send(w, late);
      repeat (3000) @(negedge mclk) if (end_of_word_strobe === 1'b1) seen = 1;
    join
    chk_bit(seen, eow);
    @(posedge mclk);
    #2;
  endtask

  task automatic take_word(input logic [31:0] exp);
    int n;
    n = 0;
    while (word_rd_valid !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #2;
      n++;
    end
    chk_bit(word_rd_valid, 1'b1);
    chk_word(word_rd_data, exp);
    word_rd_ready = 1;
    @(posedge mclk);
    #2;
    word_rd_ready = 0;
    // Let an edge pass so back-to-back takes never rewrite ready in one step
    @(posedge mclk);
    #2;
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(90_000 * 50);
    errors++;
    test_done();
  end

  initial begin
    {resetn, ctrl_wr, lbl_wr_en, word_rd_ready, tx_load, channel_reset_bit} = '0;
    {label_filter_enable, sdi_decoder_enable, bit10_match_value, bit9_match_value} = '0;
    {parity_check_enable, label_order_select, loopback_select_n} = 3'b001;
    {lbl_wr_idx, lbl_rd_idx, lbl_wr_data, tx_word} = '0;
    repeat (12) @(posedge mclk);
    #2;
    resetn = 1;
    chk_bit(fifo_empty_flags, 1'b1);
    // Entries 0 to 14 hold the wanted label, entry 15 holds label 00
    lbl_wr_en = 1;
    for (int i = 0; i < 16; i++) begin
      lbl_wr_idx = i[3:0];
      lbl_wr_data = (i == 15) ? 8'h00 : rv(8'h1b);
      @(posedge mclk);
      #2;
    end
    lbl_wr_en = 0;
    for (int i = 0; i < 16; i++) begin
      lbl_rd_idx = i[3:0];
      @(posedge mclk);
      #2;
      chk_word({24'h0, lbl_rd_data}, {24'h0, (i == 15) ? 8'h00 : rv(8'h1b)});
    end
    $display("Label test done");
    // Receiver needs three gap Null tests after reset before a first bit counts
    repeat (400) @(posedge mclk);
    #2;
    foreach (rows[i]) begin
      {label_filter_enable, sdi_decoder_enable, bit10_match_value, bit9_match_value,
       parity_check_enable, label_order_select} = rows[i].cfg;
      rx_word(rows[i].w, 99, 1'b1);
      if (rows[i].load) take_word(exp_word(rows[i].w, rows[i].cfg[1], rows[i].cfg[0]));
      else chk_bit(word_rd_valid, 1'b0);
      $display("Row %0d done", i);
    end
    {label_filter_enable, sdi_decoder_enable, parity_check_enable, label_order_select} = '0;
    rx_word(32'h0000_001b, 5, 1'b0);
    rx_word(32'h0000_0022, 99, 1'b1);
    take_word(exp_word(32'h0000_0022, 1'b0, 1'b0));
    $display("Spacing test done");
    for (int k = 0; k < 7; k++) rx_word(32'h0000_1100 + k, 99, 1'b1);
    chk_bit(fifo_full_flags, 1'b1);
    chk_bit(fifo_empty_flags, 1'b0);
    for (int k = 0; k < 6; k++) take_word(exp_word(32'h0000_1100 + (k == 5 ? 6 : k), 0, 0));
    @(posedge mclk);
    #2;
    chk_bit(fifo_empty_flags, 1'b1);
    $display("Queue test done");
    loopback_select_n = 0;
    chk_word({30'h0, tx_high_level_out, tx_low_level_out}, 32'h0);
    tx_word = 32'h0f0f_0f1b;
    tx_load = 1;
    @(posedge mclk);
    #2;
    tx_load = 0;
    @(posedge mclk);
    #2;
    chk_word({30'h0, tx_high_level_out, tx_low_level_out}, 32'h2);
    rx_word(tx_word, -1, 1'b1);
    take_word(exp_word(tx_word, 1'b0, 1'b0));
    loopback_select_n = 1;
    tx_load = 1;
    @(posedge mclk);
    #2;
    tx_load = 0;
    rx_word(tx_word, -1, 1'b0);
    $display("Loopback test done");
    rx_word(32'h0000_0055, 99, 1'b1);
    channel_reset_bit = 1;
    repeat (2) @(posedge mclk);
    #2;
    chk_bit(word_rd_valid, 1'b0);
    chk_bit(fifo_empty_flags, 1'b1);
    channel_reset_bit = 0;
    ctrl_wr = 1;
    @(posedge mclk);
    #2;
    ctrl_wr = 0;
    lbl_rd_idx = 4'h3;
    repeat (2) @(posedge mclk);
    #2;
    chk_word({24'h0, lbl_rd_data}, 32'h0);
    resetn = 0;
    repeat (2) @(posedge mclk);
    #2;
    chk_word({29'h0, fifo_empty_flags, fifo_full_flags, word_rd_valid}, 32'h4);
    resetn = 1;
    $display("Reset tests done");
    test_done();
  end
endmodule // tb_arc_rx_channel
